// ---- rbs_regs.svh ----
`ifndef RBS_REGS_SVH
`define RBS_REGS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define RBS_PC_W        21
`define RBS_DM_W        12
`define RBS_BANK_W      4

// ****************************************************************
// APB register offsets (byte addresses)
// ****************************************************************
`define RBS_ADDR_W      12
`define RBS_CTRL_OFF    12'h000
`define RBS_STAT_OFF    12'h004
`define RBS_TGT_OFF     12'h008
`define RBS_TCNT_OFF    12'h00C
`define RBS_SCNT_OFF    12'h010

// ****************************************************************
// Register fields and reset values
// ****************************************************************
`define RBS_CTRL_EN_BIT    0
`define RBS_CTRL_CLR_BIT   1
`define RBS_CTRL_RST       1'b1
`define RBS_STAT_TAKEN_BIT 0
`define RBS_STAT_NOP_BIT   1
`define RBS_STAT_BSET_BIT  2
`define RBS_STAT_EN_BIT    3
`define RBS_STAT_OP_LSB    4
`define RBS_CNT_W          16

// ****************************************************************
// Opcode fields
// ****************************************************************
`define RBS_OPC_BCOND   4'hE
`define RBS_CC_CARRY    4'h3
`define RBS_CC_NEG      4'h7
`define RBS_CC_OVF      4'h5
`define RBS_CC_ZERO     4'h1
`define RBS_OPC_BRA     5'h1A
`define RBS_OPC_BSF     4'h8
`define RBS_PC_STEP     2

// ****************************************************************
// Instruction cycle phases
// ****************************************************************
`define RBS_MCLK_HZ     20000000
`define RBS_Q_DECODE    2'h0
`define RBS_Q_FETCH     2'h1
`define RBS_Q_COMPUTE   2'h2
`define RBS_Q_WRITE     2'h3

`endif

// ---- rbs_pkg.sv ----
`default_nettype none
`include "rbs_regs.svh"

package rbs_pkg;

  typedef enum logic [1:0] {RBS_OP_NONE, RBS_OP_BCOND, RBS_OP_BRA, RBS_OP_BSET} rbs_op_e;
  typedef enum logic [1:0] {RBS_CC_C, RBS_CC_N, RBS_CC_OV, RBS_CC_Z} rbs_cond_e;

  typedef struct packed {
    logic c;
    logic n;
    logic ov;
    logic z;
  } rbs_flags_s;

  typedef struct packed {
    logic [`RBS_ADDR_W-1:0] paddr;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [31:0]            pwdata;
  } rbs_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rbs_apb_rsp_s;

  typedef struct packed {
    logic                  load;
    logic [`RBS_PC_W-1:0]  target;
  } rbs_pc_s;

  typedef struct packed {
    logic                  rd;
    logic                  we;
    logic [`RBS_DM_W-1:0]  addr;
    logic [7:0]            wdata;
  } rbs_dm_s;

  typedef struct packed {
    logic [1:0] phase;
  } rbs_qph_s;

  typedef struct packed {
    rbs_op_e                op;
    rbs_cond_e              cond;
    logic [15:0]            iw;
    logic [`RBS_PC_W-1:0]   iaddr;
    logic                   taken;
    logic                   nop;
    logic [7:0]             result;
    rbs_pc_s                pc;
    rbs_dm_s                dm;
    logic                   ctrl_en;
    logic                   taken_last;
    logic                   bset_last;
    rbs_op_e                last_op;
    logic [`RBS_PC_W-1:0]   last_tgt;
    logic [`RBS_CNT_W-1:0]  tcnt;
    logic [`RBS_CNT_W-1:0]  scnt;
    logic [31:0]            prdata;
    logic                   pslverr;
  } rbs_state_s;

endpackage

`default_nettype wire

// ---- rbs_qphase.sv ----
`default_nettype none
`include "rbs_regs.svh"

// ****************************************************************
// Four-phase sequencer: one mclk per phase
// ****************************************************************
module rbs_qphase (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  output logic [1:0]      phase
);

  rbs_pkg::rbs_qph_s st_r;
  rbs_pkg::rbs_qph_s st_nxt;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.phase = st_r.phase + 2'h1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign phase = st_r.phase;

endmodule

`default_nettype wire

// ---- rbs_exec.sv ----
// Operation
// - Short branch offset is signed -128..127, doubled to count words
// - Taken branch target is instruction address plus 2 plus twice offset
// - Conditional branch: one word, one cycle untaken, two when taken
// - Pattern E3 with offset branches only when carry is clear
// - Pattern E7 with offset branches only when negative is clear
// - Pattern E5 with offset branches only when overflow is clear
// - Pattern E1 with offset branches only when zero is clear
// - Pattern 11010 with signed 11-bit offset always branches to target
// - Pattern 1000 bbb a ffffffff sets one bit in one cycle
// - Bit set reads register, forces chosen bit high, writes back
// - Access bit low uses fixed access bank, high uses bank select
//
// The register addresses and register access over APB were chosen for this implementation.
`default_nettype none
`include "rbs_regs.svh"

module rbs_exec #(
  parameter logic [`RBS_BANK_W-1:0] ACCESS_BANK = 4'h0
) (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire rbs_pkg::rbs_apb_req_s    apb_req,
  output rbs_pkg::rbs_apb_rsp_s         apb_rsp,
  input  wire logic                     instr_valid,
  input  wire logic [15:0]              instr_word,
  input  wire logic [`RBS_PC_W-1:0]     instr_addr,
  output logic                          instr_ready,
  output logic                          instr_hit,
  input  wire rbs_pkg::rbs_flags_s      status_flags,
  input  wire logic [`RBS_BANK_W-1:0]   bank_select_register,
  output rbs_pkg::rbs_pc_s              pc_out,
  output rbs_pkg::rbs_dm_s              dm_out,
  input  wire logic [7:0]               dm_rdata,
  output logic                          status_we,
  output logic [1:0]                    phase
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic rbs_pkg::rbs_op_e decode_op(input logic [15:0] w);
    rbs_pkg::rbs_op_e op;
    op = rbs_pkg::RBS_OP_NONE;
    if (w[15:12] == `RBS_OPC_BCOND &&
        (w[11:8] == `RBS_CC_CARRY || w[11:8] == `RBS_CC_NEG ||
         w[11:8] == `RBS_CC_OVF   || w[11:8] == `RBS_CC_ZERO)) begin
      op = rbs_pkg::RBS_OP_BCOND;
    end else if (w[15:11] == `RBS_OPC_BRA) begin
      op = rbs_pkg::RBS_OP_BRA;
    end else if (w[15:12] == `RBS_OPC_BSF) begin
      op = rbs_pkg::RBS_OP_BSET;
    end
    return op;
  endfunction

  function automatic logic reg_hit(input logic [`RBS_ADDR_W-1:0] a);
    return (a == `RBS_CTRL_OFF) || (a == `RBS_STAT_OFF) || (a == `RBS_TGT_OFF) ||
           (a == `RBS_TCNT_OFF) || (a == `RBS_SCNT_OFF);
  endfunction

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************
  rbs_qphase u_qphase (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .phase   (phase)
  );

  rbs_pkg::rbs_state_s st_r;
  rbs_pkg::rbs_state_s st_nxt;

  logic [`RBS_PC_W-1:0] ofs_word;
  logic                 cond_ok;
  logic                 apb_setup;
  logic                 apb_wr;
  logic [31:0]          stat_word;

  // Offset sign-extended and shifted left once so it counts words
  always_comb begin
    if (st_r.op == rbs_pkg::RBS_OP_BRA) begin
      ofs_word = {{(`RBS_PC_W-12){st_r.iw[10]}}, st_r.iw[10:0], 1'b0};
    end else begin
      ofs_word = {{(`RBS_PC_W-9){st_r.iw[7]}}, st_r.iw[7:0], 1'b0};
    end
  end

  // Branch only on a cleared flag
  always_comb begin
    unique case (st_r.cond)
      rbs_pkg::RBS_CC_C:  cond_ok = !status_flags.c;
      rbs_pkg::RBS_CC_N:  cond_ok = !status_flags.n;
      rbs_pkg::RBS_CC_OV: cond_ok = !status_flags.ov;
      rbs_pkg::RBS_CC_Z:  cond_ok = !status_flags.z;
    endcase
  end

  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_wr    = apb_req.psel && apb_req.penable && apb_req.pwrite;

  always_comb begin
    stat_word                          = '0;
    stat_word[`RBS_STAT_TAKEN_BIT]     = st_r.taken_last;
    stat_word[`RBS_STAT_NOP_BIT]       = st_r.nop;
    stat_word[`RBS_STAT_BSET_BIT]      = st_r.bset_last;
    stat_word[`RBS_STAT_EN_BIT]        = st_r.ctrl_en;
    stat_word[`RBS_STAT_OP_LSB +: 2]   = st_r.last_op;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pc.load = 1'b0;
    st_nxt.dm.we   = 1'b0;
    st_nxt.dm.rd   = 1'b0;

    unique case (phase)
      `RBS_Q_DECODE: begin
        st_nxt.op    = rbs_pkg::RBS_OP_NONE;
        st_nxt.taken = 1'b0;
        if (instr_ready && instr_valid) begin
          st_nxt.iw    = instr_word;
          st_nxt.iaddr = instr_addr;
          st_nxt.op    = decode_op(instr_word);
          unique case (instr_word[11:8])
            `RBS_CC_CARRY: st_nxt.cond = rbs_pkg::RBS_CC_C;
            `RBS_CC_NEG:   st_nxt.cond = rbs_pkg::RBS_CC_N;
            `RBS_CC_OVF:   st_nxt.cond = rbs_pkg::RBS_CC_OV;
            default:       st_nxt.cond = rbs_pkg::RBS_CC_Z;
          endcase
          if (decode_op(instr_word) == rbs_pkg::RBS_OP_BSET) begin
            // Access bank overrides the bank select register when a is low
            st_nxt.dm.addr = {instr_word[8] ? bank_select_register : ACCESS_BANK,
                              instr_word[7:0]};
            st_nxt.dm.rd   = 1'b1;
          end
        end
      end
      `RBS_Q_FETCH: begin
        if (st_r.op == rbs_pkg::RBS_OP_BSET) begin
          st_nxt.result = dm_rdata;
        end
      end
      `RBS_Q_COMPUTE: begin
        unique case (st_r.op)
          rbs_pkg::RBS_OP_BCOND: begin
            st_nxt.taken = cond_ok;
          end
          rbs_pkg::RBS_OP_BRA: begin
            st_nxt.taken = 1'b1;
          end
          rbs_pkg::RBS_OP_BSET: begin
            st_nxt.result = st_r.result | (8'h01 << st_r.iw[11:9]);
          end
          rbs_pkg::RBS_OP_NONE: begin
            st_nxt.taken = 1'b0;
          end
        endcase
        st_nxt.pc.target = st_r.iaddr + `RBS_PC_W'(`RBS_PC_STEP) + ofs_word;
        st_nxt.dm.wdata  = st_nxt.result;
        // Strobes registered here so they stand exactly through the write phase
        st_nxt.pc.load   = st_nxt.taken;
        st_nxt.dm.we     = (st_r.op == rbs_pkg::RBS_OP_BSET);
      end
      `RBS_Q_WRITE: begin
        // A taken branch idles through the whole following cycle
        st_nxt.nop = st_r.taken;
        if (st_r.taken) begin
          st_nxt.last_tgt = st_r.pc.target;
          st_nxt.tcnt     = st_r.tcnt + `RBS_CNT_W'(1);
        end
        if (st_r.op == rbs_pkg::RBS_OP_BSET) begin
          st_nxt.scnt  = st_r.scnt + `RBS_CNT_W'(1);
        end
        if (st_r.op != rbs_pkg::RBS_OP_NONE) begin
          st_nxt.last_op    = st_r.op;
          st_nxt.taken_last = st_r.taken;
          st_nxt.bset_last  = (st_r.op == rbs_pkg::RBS_OP_BSET);
        end
      end
    endcase

    // APB: read data is latched in the setup phase so the slave never waits
    if (apb_setup) begin
      st_nxt.pslverr = !reg_hit(apb_req.paddr);
      unique case (apb_req.paddr)
        `RBS_CTRL_OFF: st_nxt.prdata = {31'h0, st_r.ctrl_en};
        `RBS_STAT_OFF: st_nxt.prdata = stat_word;
        `RBS_TGT_OFF:  st_nxt.prdata = {{(32-`RBS_PC_W){1'b0}}, st_r.last_tgt};
        `RBS_TCNT_OFF: st_nxt.prdata = {{(32-`RBS_CNT_W){1'b0}}, st_r.tcnt};
        `RBS_SCNT_OFF: st_nxt.prdata = {{(32-`RBS_CNT_W){1'b0}}, st_r.scnt};
        default:       st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_wr && apb_req.paddr == `RBS_CTRL_OFF) begin
      st_nxt.ctrl_en = apb_req.pwdata[`RBS_CTRL_EN_BIT];
      // Clear is a one-shot action; software clear loses to a count event
      if (apb_req.pwdata[`RBS_CTRL_CLR_BIT]) begin
        if (!(phase == `RBS_Q_WRITE && st_r.taken)) begin
          st_nxt.tcnt = '0;
        end
        if (!(phase == `RBS_Q_WRITE && st_r.op == rbs_pkg::RBS_OP_BSET)) begin
          st_nxt.scnt = '0;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r         <= '0;
      st_r.ctrl_en <= `RBS_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Word is consumed only at decode, never during the idle cycle
  assign instr_ready     = (phase == `RBS_Q_DECODE) && !st_r.nop && st_r.ctrl_en;
  assign instr_hit       = decode_op(instr_word) != rbs_pkg::RBS_OP_NONE;
  assign pc_out          = st_r.pc;
  assign dm_out          = st_r.dm;
  // Flags are never written by this block, taken or not
  assign status_we       = 1'b0;
  assign apb_rsp.prdata  = st_r.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && st_r.pslverr;

endmodule

`default_nettype wire

// ---- rbs_exec_sva.sv ----
`default_nettype none
`include "rbs_regs.svh"

// ****************************************************************
// Port-level checks of the branch and bit-set executor
// ****************************************************************
module rbs_exec_sva #(
  parameter logic [`RBS_BANK_W-1:0] ACCESS_BANK = 4'h0
) (
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  input wire rbs_pkg::rbs_apb_req_s  apb_req,
  input wire rbs_pkg::rbs_apb_rsp_s  apb_rsp,
  input wire logic                   instr_valid,
  input wire logic [15:0]            instr_word,
  input wire logic [`RBS_PC_W-1:0]   instr_addr,
  input wire logic                   instr_ready,
  input wire logic                   instr_hit,
  input wire rbs_pkg::rbs_flags_s    status_flags,
  input wire logic [`RBS_BANK_W-1:0] bank_select_register,
  input wire rbs_pkg::rbs_pc_s       pc_out,
  input wire rbs_pkg::rbs_dm_s       dm_out,
  input wire logic [7:0]             dm_rdata,
  input wire logic                   status_we,
  input wire logic [1:0]             phase
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  wire logic        take = phase == 2'h0 && instr_valid && instr_ready;
  wire logic        is_bc = instr_word[15:12] == 4'hE && !instr_word[11] && instr_word[8];
  wire logic        is_bra = instr_word[15:11] == 5'h1A;
  wire logic        is_bs = instr_word[15:12] == 4'h8;
  wire logic [20:0] tgt8 = instr_addr + 21'h2 + {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
  wire logic [20:0] tgt11 = instr_addr + 21'h2 + {{9{instr_word[10]}}, instr_word[10:0], 1'b0};

  // Condition field in bits 10:9: zero, carry, overflow, negative
  function automatic logic pick(logic [1:0] c, rbs_pkg::rbs_flags_s f);
    return c == 2'h0 ? f.z : c == 2'h1 ? f.c : c == 2'h2 ? f.ov : f.n;
  endfunction

  property p_bra;
    logic [20:0] t;
    (take && is_bra, t = tgt11) |-> ##3 (pc_out.load && pc_out.target == t);
  endproperty
  property p_bcond;
    logic [20:0] t;
    logic [1:0] c;
    logic f;
    (take && is_bc, t = tgt8, c = instr_word[10:9]) ##2 (1'b1, f = pick(c, status_flags))
      |-> ##1 (pc_out.load == !f && (f || pc_out.target == t));
  endproperty
  property p_idle;
    pc_out.load |=> !instr_ready;
  endproperty
  property p_bset_rd;
    logic [11:0] a;
    (take && is_bs, a = {instr_word[8] ? bank_select_register : ACCESS_BANK, instr_word[7:0]})
      |=> dm_out.rd && dm_out.addr == a;
  endproperty
  property p_bset_we;
    logic [2:0] b;
    logic [7:0] r;
    (take && is_bs, b = instr_word[11:9]) ##1 (1'b1, r = dm_rdata)
      |-> ##2 (dm_out.we && dm_out.wdata == (r | (8'h01 << b)));
  endproperty
  property p_wphase;
    pc_out.load || dm_out.we |-> phase == 2'h3;
  endproperty
  property p_flags;
    status_we == 1'b0;
  endproperty
  property p_foreign;
    take && !instr_hit |-> ##3 !pc_out.load && !dm_out.we;
  endproperty
  property p_pready;
    apb_req.psel && apb_req.penable |-> apb_rsp.pready;
  endproperty

  a_bra:     assert property (p_bra) else $error("branch always target wrong");
  a_bcond:   assert property (p_bcond) else $error("conditional branch wrong");
  a_idle:    assert property (p_idle) else $error("no idle cycle after branch");
  a_bset_rd: assert property (p_bset_rd) else $error("bit set address wrong");
  a_bset_we: assert property (p_bset_we) else $error("bit set write wrong");
  a_wphase:  assert property (p_wphase) else $error("write outside last phase");
  a_flags:   assert property (p_flags) else $error("status flags written");
  a_foreign: assert property (p_foreign) else $error("foreign opcode acted");
  a_pready:  assert property (p_pready) else $error("access phase not ready");

  c_taken: cover property (take && is_bc ##3 pc_out.load);
  c_bra:   cover property (take && is_bra ##3 pc_out.load);
  c_bset:  cover property (dm_out.we);
endmodule

`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
`include "rbs_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

// ****************************************************************
// Random and corner-case instruction stream with APB readback
// ****************************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  mclk = 1'b0;
  logic                  sys_rst = 1'b1;
  rbs_pkg::rbs_apb_req_s apb_req = '0;
  rbs_pkg::rbs_apb_rsp_s apb_rsp;
  logic                  instr_valid = 1'b0;
  logic [15:0]           instr_word = 16'h0000;
  logic [20:0]           instr_addr = 21'h0;
  logic                  instr_ready;
  logic                  instr_hit;
  rbs_pkg::rbs_flags_s   status_flags = '0;
  logic [3:0]            bank_select_register = 4'h0;
  rbs_pkg::rbs_pc_s      pc_out;
  rbs_pkg::rbs_dm_s      dm_out;
  logic [7:0]            dm_rdata = 8'h00;
  logic                  status_we;
  logic [1:0]            phase;
  logic [31:0]           seed = 32'h69D456D7;
  logic [31:0]           q;
  logic                  e;
  logic [20:0]           last_tgt = 21'h0;
  logic [31:0]           exp_stat = 32'h0;
  int                    n_mismatch = 0;
  int                    cmp_count = 0;
  int                    n_taken = 0;
  int                    n_bset = 0;
  logic [15:0]           corner [8] = '{16'hE380, 16'hE77F, 16'hE501, 16'hE10A,
                                        16'hD400, 16'hD3FF, 16'h8F12, 16'hFFFF};

  rbs_exec dut (.mclk(mclk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr),
    .instr_ready(instr_ready), .instr_hit(instr_hit), .status_flags(status_flags),
    .bank_select_register(bank_select_register), .pc_out(pc_out), .dm_out(dm_out),
    .dm_rdata(dm_rdata), .status_we(status_we), .phase(phase));

  always #25 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction
  function automatic logic is_bc(logic [15:0] w);
    return w[15:12] == 4'hE && !w[11] && w[8];
  endfunction
  function automatic logic exp_taken(logic [15:0] w, rbs_pkg::rbs_flags_s f);
    if (w[15:11] == 5'h1A) return 1'b1;
    if (!is_bc(w)) return 1'b0;
    case (w[10:9])
      2'h0: return !f.z;
      2'h1: return !f.c;
      2'h2: return !f.ov;
      default: return !f.n;
    endcase
  endfunction
  function automatic logic [20:0] exp_tgt(logic [15:0] w, logic [20:0] a);
    if (w[15:11] == 5'h1A) return a + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0};
    return a + 21'h2 + {{12{w[7]}}, w[7:0], 1'b0};
  endfunction

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (i == 20) begin n_mismatch++; close_out(); end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // Everything the instruction needs is set before its decode phase and held
  task automatic run(input logic [15:0] w);
    logic [31:0] r;
    logic [20:0] a;
    logic        tk;
    logic        bs;
    int          i;
    r = rnd();
    a = {r[20:1], 1'b0};
    tk = exp_taken(w, rbs_pkg::rbs_flags_s'(r[24:21]));
    bs = w[15:12] == 4'h8;
    @(posedge mclk);
    instr_word <= w;
    instr_addr <= a;
    status_flags <= rbs_pkg::rbs_flags_s'(r[24:21]);
    bank_select_register <= r[28:25];
    dm_rdata <= r[31:24];
    instr_valid <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge mclk);
      if (phase === 2'h0 && instr_ready === 1'b1) break;
    end
    if (i == 20) begin n_mismatch++; close_out(); end
    `CHK("hit", is_bc(w) || w[15:11] == 5'h1A || bs, instr_hit)
    @(posedge mclk);
    instr_valid <= 1'b0;
    @(negedge mclk);
    if (bs) `CHK("dm_addr", {w[8] ? r[28:25] : 4'h0, w[7:0]}, dm_out.addr)
    `CHK("dm_rd", bs, dm_out.rd)
    repeat (2) @(negedge mclk);
    `CHK("load", tk, pc_out.load)
    if (tk) `CHK("target", exp_tgt(w, a), pc_out.target)
    `CHK("we", bs, dm_out.we)
    if (bs) `CHK("wdata", r[31:24] | (8'h01 << w[11:9]), dm_out.wdata)
    `CHK("flags_we", 1'b0, status_we)
    @(negedge mclk);
    `CHK("ready", !tk, instr_ready)
    n_taken += tk;
    n_bset += bs;
    if (tk) last_tgt = exp_tgt(w, a);
    if (is_bc(w) || w[15:11] == 5'h1A || bs)
      exp_stat = {26'h0, bs ? 2'h3 : is_bc(w) ? 2'h1 : 2'h2, 1'b1, bs, 1'b0, tk};
  endtask

  initial begin
    logic [31:0] r;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, `RBS_CTRL_OFF, 32'h0);
    `CHK("ctrl_reset", 32'h00000001, q)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("miss_err", 1'b1, e)
    foreach (corner[k]) run(corner[k]);
    for (int k = 0; k < 60; k++) begin
      r = rnd();
      case (r[2:0] % 3'h6)
        3'h4: run({5'h1A, r[13:3]});
        3'h5: run({4'h8, r[14:3]});
        default: run({4'hE, 1'b0, r[1:0], 1'b1, r[10:3]});
      endcase
    end
    apb(1'b0, `RBS_TCNT_OFF, 32'h0);
    `CHK("taken_count", n_taken, q)
    apb(1'b0, `RBS_SCNT_OFF, 32'h0);
    `CHK("set_count", n_bset, q)
    apb(1'b0, `RBS_TGT_OFF, 32'h0);
    `CHK("last_target", {11'h0, last_tgt}, q)
    apb(1'b0, `RBS_STAT_OFF, 32'h0);
    `CHK("status", exp_stat, q)
    apb(1'b1, `RBS_CTRL_OFF, 32'h00000003);
    apb(1'b0, `RBS_TCNT_OFF, 32'h0);
    `CHK("count_clear", 32'h0, q)
    apb(1'b1, `RBS_CTRL_OFF, 32'h0);
    repeat (4) begin
      @(negedge mclk);
      `CHK("refused", 1'b0, instr_ready)
    end
    close_out();
  end
endmodule

bind rbs_exec rbs_exec_sva #(.ACCESS_BANK(ACCESS_BANK)) u_sva (.mclk(mclk), .sys_rst(sys_rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_addr(instr_addr), .instr_ready(instr_ready), .instr_hit(instr_hit),
  .status_flags(status_flags), .bank_select_register(bank_select_register),
  .pc_out(pc_out), .dm_out(dm_out), .dm_rdata(dm_rdata), .status_we(status_we), .phase(phase));

`default_nettype wire
